//--- atsr_core.v
// Address termination and snoop response logic with an APB register slave.
`timescale 1ns/1ps
`include "atsr_regs.vh"

module atsr_core (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        transfer_start_n,
	input  wire        extended_transfer_start_n,
	input  wire        address_acknowledge_n,
	input  wire        address_bus_busy_n,
	input  wire        address_retry_in_n,
	input  wire        snoop_shared_in_n,
	input  wire        priority_snoop_request_n,
	input  wire        own_start,
	input  wire        own_read,
	input  wire        own_data_active,
	input  wire        own_request,
	input  wire [1:0]  cache_way,
	input  wire        touch_load,
	input  wire        snoop_retry_needed,
	input  wire        snoop_hit_modified,
	input  wire        snoop_keeps_shared,
	output reg         address_oe_n,
	output reg  [1:0]  cache_way_select,
	output reg         cache_way_select_oe_n,
	output reg         address_retry_out,
	output reg         address_retry_oe_n,
	output reg         snoop_shared_out,
	output reg         snoop_shared_oe_n,
	output reg         bus_request_n,
	output reg         priority_slot_open,
	output reg         repeat_tenure,
	output reg         data_abort,
	output reg         push_next,
	output reg         alloc_shared,
	output reg         alloc_exclusive
);

// ----------------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------------
	reg [5:0] meta_ff;
	reg [5:0] sync_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 6'h3F;
			sync_ff <= 6'h3F;
		end else begin
			meta_ff <= {priority_snoop_request_n, snoop_shared_in_n, address_retry_in_n,
				address_bus_busy_n, address_acknowledge_n,
				transfer_start_n & extended_transfer_start_n};
			sync_ff <= meta_ff;
		end
	end

	wire ts_s    = ~sync_ff[0];
	wire address_acknowledge_s  = ~sync_ff[1];
	wire abb_s   = ~sync_ff[2];
	wire retry_s = ~sync_ff[3];
	wire shd_s   = ~sync_ff[4];
	wire prio_s  = ~sync_ff[5];

// ----------------------------------------------------------------------
// Registers and APB slave
// ----------------------------------------------------------------------
	reg  [31:0] cfg_ff;
	reg  [3:0]  ctrl_ff;
	reg  [31:0] status_w;
	wire        acc      = psel & penable & ~pready;
	wire        wr_go    = psel & penable & pready & pwrite;
	wire        hit_cfg  = (paddr == `ATSR_ADDR_CFG);
	wire        hit_ctrl = (paddr == `ATSR_ADDR_CTRL);
	wire        hit_stat = (paddr == `ATSR_ADDR_STATUS);
	wire [1:0]  variant  = ctrl_ff[`ATSR_CTRL_VAR_HI:`ATSR_CTRL_VAR_LO];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff  <= `ATSR_CFG_RESET;
			ctrl_ff <= `ATSR_CTRL_RESET;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= acc;
			pslverr <= acc & ~(hit_cfg | hit_ctrl | hit_stat);
			prdata  <= 32'h00000000;
			if (wr_go && hit_cfg) begin
				cfg_ff <= pwdata & `ATSR_CFG_MASK;
			end
			if (wr_go && hit_ctrl) begin
				ctrl_ff <= pwdata[3:0];
			end
			if (acc && !pwrite) begin
				if (hit_cfg) begin
					prdata <= cfg_ff;
				end else if (hit_ctrl) begin
					prdata <= {28'h0000000, ctrl_ff};
				end else if (hit_stat) begin
					prdata <= status_w;
				end
			end
		end
	end

// ----------------------------------------------------------------------
// Own address tenure as bus master
// ----------------------------------------------------------------------
	localparam M_IDLE  = 2'h0;
	localparam M_ADDR  = 2'h1;
	localparam M_RSMP  = 2'h2;

	reg [1:0] mst_ff;
	reg [1:0] nxt_mst;
	reg [2:0] mage_ff;
	reg       mread_ff;
	reg       retry_early_ff;
	reg       retried_w;

	always @* begin
		nxt_mst   = mst_ff;
		retried_w = 1'b0;
		case (mst_ff)
			M_IDLE: begin
				if (own_start) begin
					nxt_mst = M_ADDR;
				end
			end
			M_ADDR: begin
				if (address_acknowledge_s) begin
					nxt_mst = M_RSMP;
				end
			end
			M_RSMP: begin
				retried_w = retry_s | retry_early_ff;
				nxt_mst   = M_IDLE;
			end
			default: begin
				nxt_mst = M_IDLE;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mst_ff                <= M_IDLE;
			mage_ff               <= 3'h0;
			mread_ff              <= 1'b0;
			retry_early_ff        <= 1'b0;
			address_oe_n          <= 1'b1;
			cache_way_select      <= 2'h0;
			cache_way_select_oe_n <= 1'b1;
			repeat_tenure         <= 1'b0;
			data_abort            <= 1'b0;
			alloc_shared          <= 1'b0;
			alloc_exclusive       <= 1'b0;
		end else begin
			mst_ff <= nxt_mst;
			if (own_start && mst_ff == M_IDLE) begin
				mage_ff        <= 3'h0;
				mread_ff       <= own_read;
				retry_early_ff <= 1'b0;
				if (ctrl_ff[`ATSR_CTRL_ONE_WAY] && touch_load) begin
					cache_way_select <= 2'h0;
				end else begin
					cache_way_select <= cache_way;
				end
			end else if (mst_ff == M_ADDR) begin
				if (mage_ff != 3'h7) begin
					mage_ff <= mage_ff + 3'h1;
				end
				if (ctrl_ff[`ATSR_CTRL_EARLY] && mage_ff >= 3'h1 && retry_s) begin
					retry_early_ff <= 1'b1;
				end
			end
			// Address and way outputs drive until acknowledge, then float.
			address_oe_n          <= ~(nxt_mst == M_ADDR);
			cache_way_select_oe_n <= ~(nxt_mst == M_ADDR);
			repeat_tenure         <= retried_w;
			data_abort            <= retried_w & own_data_active;
			alloc_shared          <= (mst_ff == M_RSMP) & ~retried_w & mread_ff & shd_s;
			alloc_exclusive       <= (mst_ff == M_RSMP) & ~retried_w & mread_ff & ~shd_s;
		end
	end

// ----------------------------------------------------------------------
// Snoop response
// ----------------------------------------------------------------------
	localparam S_IDLE = 3'h0;
	localparam S_WAIT = 3'h1;
	localparam S_ACK1 = 3'h2;
	localparam S_NEG1 = 3'h3;
	localparam S_NEG2 = 3'h4;
	localparam S_NEG3 = 3'h5;

	reg [2:0] snp_ff;
	reg [2:0] nxt_snp;
	reg [2:0] sage_ff;
	reg       sretry_ff;
	reg       sshared_ff;
	reg       smod_ff;
	reg       drive_w;
	reg       pulse_w;
	wire      neg_off = (variant == `ATSR_VAR_A) ? cfg_ff[`ATSR_CFG_NEGA_DIS] :
		(variant == `ATSR_VAR_B) ? cfg_ff[`ATSR_CFG_NEGB_DIS] : 1'b0;

	always @* begin
		nxt_snp = snp_ff;
		drive_w = 1'b0;
		pulse_w = 1'b0;
		case (snp_ff)
			S_IDLE: begin
				if (ts_s && mst_ff == M_IDLE && !own_start) begin
					nxt_snp = S_WAIT;
				end
			end
			S_WAIT: begin
				drive_w = (sage_ff >= `ATSR_RETRY_AGE);
				if (address_acknowledge_s) begin
					nxt_snp = S_ACK1;
				end
			end
			S_ACK1: begin
				drive_w = 1'b1;
				nxt_snp = S_NEG1;
			end
			S_NEG1: begin
				// Variant C drives high at once; A and B float first.
				pulse_w = (variant == `ATSR_VAR_C);
				nxt_snp = S_NEG2;
			end
			S_NEG2: begin
				pulse_w = (variant != `ATSR_VAR_C) & ~neg_off;
				nxt_snp = S_NEG3;
			end
			S_NEG3: begin
				nxt_snp = S_IDLE;
			end
			default: begin
				nxt_snp = S_IDLE;
			end
		endcase
	end

	reg [1:0] hold_ff;
	reg       push_pend_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snp_ff             <= S_IDLE;
			sage_ff            <= 3'h0;
			sretry_ff          <= 1'b0;
			sshared_ff         <= 1'b0;
			smod_ff            <= 1'b0;
			address_retry_out  <= 1'b1;
			address_retry_oe_n <= 1'b1;
			snoop_shared_out   <= 1'b1;
			snoop_shared_oe_n  <= 1'b1;
			hold_ff            <= 2'h0;
			push_pend_ff       <= 1'b0;
			bus_request_n      <= 1'b1;
			push_next          <= 1'b0;
			priority_slot_open <= 1'b0;
		end else begin
			snp_ff <= nxt_snp;
			if (snp_ff == S_IDLE) begin
				sage_ff    <= 3'h1;
				sretry_ff  <= snoop_retry_needed;
				sshared_ff <= snoop_keeps_shared | snoop_hit_modified;
				smod_ff    <= snoop_hit_modified;
			end else if (sage_ff != 3'h7) begin
				sage_ff <= sage_ff + 3'h1;
			end
			// Retry and shared pull low only while driving; otherwise float or pulse high.
			address_retry_oe_n <= ~((drive_w & sretry_ff) | (pulse_w & sretry_ff));
			address_retry_out  <= ~(drive_w & sretry_ff);
			snoop_shared_oe_n  <= ~((drive_w | pulse_w) & sshared_ff);
			snoop_shared_out   <= ~(drive_w & sshared_ff);
			push_next          <= (snp_ff == S_ACK1) & sretry_ff & smod_ff;
			if (snp_ff == S_ACK1 && sretry_ff && smod_ff) begin
				push_pend_ff <= 1'b1;
			end else if (push_pend_ff && !bus_request_n) begin
				push_pend_ff <= 1'b0;
			end
			if (retry_s && mst_ff == M_IDLE && hold_ff == 2'h0 && !push_pend_ff) begin
				hold_ff <= `ATSR_WITHHOLD_CYC;
			end else if (hold_ff != 2'h0) begin
				hold_ff <= hold_ff - 2'h1;
			end
			if (retried_w || (mst_ff == M_RSMP && retry_s)) begin
				bus_request_n <= 1'b1;
			end else if (snp_ff == S_NEG1 && push_pend_ff) begin
				bus_request_n <= 1'b0;
			end else if (hold_ff != 2'h0 || (retry_s && mst_ff == M_IDLE && !push_pend_ff)) begin
				bus_request_n <= 1'b1;
			end else begin
				bus_request_n <= ~(own_request | push_pend_ff);
			end
			priority_slot_open <= cfg_ff[`ATSR_CFG_PRIO_EN] & prio_s;
		end
	end

	always @* begin
		status_w = {21'h000000, push_pend_ff, hold_ff, snp_ff, mst_ff, prio_s, abb_s,
			~bus_request_n};
	end

endmodule

//--- atsr_regs.vh
// Register offsets, field positions, reset values and timing counts of the snoop response block.
`ifndef ATSR_REGS_VH
`define ATSR_REGS_VH
`define ATSR_ADDR_CFG        12'h000
`define ATSR_ADDR_CTRL       12'h004
`define ATSR_ADDR_STATUS     12'h008
`define ATSR_CFG_PRIO_EN     31
`define ATSR_CFG_NEGA_DIS    29
`define ATSR_CFG_NEGB_DIS    7
`define ATSR_CFG_RESET       32'h00000000
`define ATSR_CFG_MASK        32'hA0000080
`define ATSR_CTRL_VAR_LO     0
`define ATSR_CTRL_VAR_HI     1
`define ATSR_CTRL_ONE_WAY    2
`define ATSR_CTRL_EARLY      3
`define ATSR_CTRL_RESET      4'h0
`define ATSR_VAR_A           2'h0
`define ATSR_VAR_B           2'h1
`define ATSR_VAR_C           2'h2
`define ATSR_RETRY_AGE       3'h2
`define ATSR_WITHHOLD_CYC    2'h1
`endif

//--- atsr_chk.sv
// Assertion checker of the snoop response block.
`timescale 1ns/1ps
module atsr_chk (
	input logic pclk,
	input logic presetn,
	input logic address_acknowledge_n,
	input logic priority_snoop_request_n,
	input logic address_oe_n,
	input logic cache_way_select_oe_n,
	input logic bus_request_n,
	input logic priority_slot_open,
	input logic repeat_tenure,
	input logic data_abort,
	input logic push_next,
	input logic alloc_shared,
	input logic alloc_exclusive
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_WAY: assert property (cache_way_select_oe_n == address_oe_n)
		else $error("way drive differs from address drive");
	AST_HOLD: assert property (!address_oe_n && address_acknowledge_n
		&& $past(address_acknowledge_n) && $past(address_acknowledge_n, 2) |=> !address_oe_n)
		else $error("address released early");
	AST_FREE: assert property (!address_acknowledge_n && !address_oe_n |-> ##3 address_oe_n)
		else $error("address not released");
	AST_DROP: assert property (repeat_tenure |-> bus_request_n)
		else $error("request kept on retry");
	AST_ABORT: assert property (data_abort |-> repeat_tenure)
		else $error("abort without retry");
	AST_ALLOC: assert property (alloc_shared |-> !alloc_exclusive && !repeat_tenure)
		else $error("allocation clash");
	AST_PUSH: assert property (push_next |-> ##[0:1] !bus_request_n)
		else $error("push without request");
	AST_SLOT: assert property (priority_snoop_request_n [*4] |-> !priority_slot_open)
		else $error("slot open while request negated");
endmodule
bind atsr_core atsr_chk atsr_chk_inst (.pclk, .presetn, .address_acknowledge_n,
	.priority_snoop_request_n, .address_oe_n, .cache_way_select_oe_n, .bus_request_n,
	.priority_slot_open, .repeat_tenure, .data_abort, .push_next, .alloc_shared, .alloc_exclusive);

//--- atsr_far.sv
// Far-side model: address arbiter and other snooping masters.
`timescale 1ns/1ps
module atsr_far (
	input  logic       pclk,
	input  logic       presetn,
	input  logic       go,
	input  logic [6:0] cmd,
	output logic       transfer_start_n,
	output logic       extended_transfer_start_n,
	output logic       address_acknowledge_n,
	output logic       address_bus_busy_n,
	output logic       retry_pull_n,
	output logic       shared_pull_n,
	output logic       busy
);
	logic [4:0] cnt_ff;
	logic [4:0] ack_at;
	logic       win;
	assign ack_at = {1'b0, cmd[3:0]} + 5'h01;
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			cnt_ff <= 5'h00;
		else if (go)
			cnt_ff <= 5'h01;
		else if (busy)
			cnt_ff <= (cnt_ff == ack_at + 5'h05) ? 5'h00 : cnt_ff + 5'h01;
	assign busy = cnt_ff != 5'h00;
	assign transfer_start_n = !(cmd[6] && cnt_ff == 5'h01);
	assign extended_transfer_start_n = 1'b1;
	assign address_bus_busy_n = !(busy && cnt_ff <= ack_at);
	assign address_acknowledge_n = !(cnt_ff == ack_at);
	assign win = cnt_ff >= 5'h03 && cnt_ff <= ack_at + 5'h01;
	assign retry_pull_n = !(cmd[5] && win);
	assign shared_pull_n = !(cmd[4] && win);
endmodule

//--- atsr_tb.sv
// Self-checking testbench of the snoop response block.
`timescale 1ns/1ps
`include "atsr_regs.vh"
module testbench;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0, go = 0;
	logic        own_start = 0, own_read = 0, own_data_active = 0, snoop_retry_needed = 0;
	logic        snoop_hit_modified = 0, priority_snoop_request_n = 1, pready, pslverr, busy;
	logic        retry_pull_n, shared_pull_n, transfer_start_n, extended_transfer_start_n;
	logic        address_acknowledge_n, address_bus_busy_n, address_oe_n, cache_way_select_oe_n;
	logic        address_retry_out, address_retry_oe_n, snoop_shared_out, snoop_shared_oe_n;
	logic        bus_request_n, priority_slot_open, repeat_tenure, data_abort, push_next;
	logic        alloc_shared, alloc_exclusive, touch_load = 0, snoop_keeps_shared = 0;
	logic        own_request = 0;
	logic [1:0]  cache_way = 2'h2, cache_way_select;
	logic [6:0]  cmd = 7'h01;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata;
	int          fail_count = 0, samples_checked = 0, n[8];
	wire address_retry_in_n = retry_pull_n & (address_retry_oe_n | address_retry_out);
	wire snoop_shared_in_n = shared_pull_n & (snoop_shared_oe_n | snoop_shared_out);
	wire [7:0] ev = {repeat_tenure, data_abort, push_next, alloc_shared, alloc_exclusive,
		!address_retry_oe_n && !address_retry_out, !snoop_shared_oe_n && !snoop_shared_out,
		!bus_request_n};
	always #4 pclk = ~pclk;
	always @(posedge pclk)
		foreach (n[i])
			n[i] <= clr ? 0 : n[i] + ev[7 - i];
	atsr_core atsr_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .transfer_start_n, .extended_transfer_start_n, .address_acknowledge_n,
		.address_bus_busy_n, .address_retry_in_n, .snoop_shared_in_n, .priority_snoop_request_n,
		.own_start, .own_read, .own_data_active, .own_request, .cache_way,
		.touch_load, .snoop_retry_needed, .snoop_hit_modified, .snoop_keeps_shared,
		.address_oe_n, .cache_way_select, .cache_way_select_oe_n, .address_retry_out,
		.address_retry_oe_n, .snoop_shared_out, .snoop_shared_oe_n, .bus_request_n,
		.priority_slot_open, .repeat_tenure, .data_abort, .push_next, .alloc_shared,
		.alloc_exclusive);
	atsr_far atsr_far_inst (.pclk, .presetn, .go, .cmd, .transfer_start_n,
		.extended_transfer_start_n, .address_acknowledge_n, .address_bus_busy_n, .retry_pull_n,
		.shared_pull_n, .busy);
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stall;
		fail_count++;
		$display("Error at %0t: wait timed out", $time);
		report_and_stop();
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, x, input logic e);
		int t;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1;
		t = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
		{psel, penable} <= 2'h0;
		if (t >= 20)
			stall();
		chk(pslverr, e);
		if (!w)
			chk(prdata, x);
	endtask
	task automatic tenure(input logic [6:0] c, input logic [7:0] x);
		int t;
		@(posedge pclk);
		cmd <= c;
		{go, own_start, clr} <= {1'b1, !c[6], 1'b1};
		@(posedge pclk);
		{go, own_start, clr} <= 3'h0;
		t = 0;
		do @(posedge pclk); while (busy === 1'b1 && ++t < 40);
		if (t >= 40)
			stall();
		repeat (6) @(posedge pclk);
		chk({n[0] == 1, n[1] == 1, n[2] == 1, n[3] == 1, n[4] == 1, n[5] != 0, n[6] != 0,
			n[7] != 0}, x);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		apb(0, `ATSR_ADDR_CFG, 0, `ATSR_CFG_RESET, 0);
		apb(0, `ATSR_ADDR_CTRL, 0, 0, 0);
		apb(1, `ATSR_ADDR_CFG, 32'hFFFFFFFF, 0, 0);
		apb(0, `ATSR_ADDR_CFG, 0, `ATSR_CFG_MASK, 0);
		apb(1, 12'h00C, 32'h00000001, 0, 1);
		apb(0, 12'h00C, 0, 0, 1);
		apb(1, `ATSR_ADDR_CFG, 0, 0, 0);
		$display("test registers done");
		snoop_retry_needed <= 1;
		snoop_hit_modified <= 1;
		for (int v = 0; v < 3; v++) begin
			apb(1, `ATSR_ADDR_CTRL, v, 0, 0);
			apb(0, `ATSR_ADDR_CTRL, 0, v, 0);
			tenure(7'h45, 8'h27);
		end
		snoop_retry_needed <= 0;
		snoop_hit_modified <= 0;
		snoop_keeps_shared <= 1;
		tenure(7'h45, 8'h02);
		snoop_keeps_shared <= 0;
		$display("test snoop done");
		own_read <= 1;
		tenure(7'h01, 8'h08);
		chk(cache_way_select, 2'h2);
		apb(1, `ATSR_ADDR_CTRL, 32'h00000004, 0, 0);
		touch_load <= 1;
		tenure(7'h01, 8'h08);
		chk(cache_way_select, 2'h0);
		touch_load <= 0;
		tenure(7'h14, 8'h10);
		own_data_active <= 1;
		own_request <= 1;
		apb(1, `ATSR_ADDR_CTRL, 32'h00000008, 0, 0);
		tenure(7'h22, 8'hC1);
		own_request <= 0;
		$display("test own tenure done");
		priority_snoop_request_n <= 0;
		repeat (6) @(posedge pclk);
		chk(priority_slot_open, 0);
		apb(1, `ATSR_ADDR_CFG, 32'h80000000, 0, 0);
		repeat (6) @(posedge pclk);
		chk(priority_slot_open, 1);
		priority_snoop_request_n <= 1;
		repeat (6) @(posedge pclk);
		chk(priority_slot_open, 0);
		$display("test priority done");
		report_and_stop();
	end
endmodule
